/* design/wobble_mark_pkg.sv */
// Shared constants and types for the wobble-mark track offset block
package wobble_mark_pkg;

  // Sub-field geometry, in channel bit periods (T)
  localparam int unsigned FIELD_LEN_T    = 64;
  localparam int unsigned SUBFIELD_LEN_T = 16;
  localparam int unsigned SAMPLE_POS_T   = SUBFIELD_LEN_T / 2;
  localparam int unsigned HEADER_LIMIT_T = 4095;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_THRESH  = 8'h04;
  localparam logic [7:0] REG_TIMING  = 8'h08;
  localparam logic [7:0] REG_STATUS  = 8'h0c;
  localparam logic [7:0] REG_OFFSET  = 8'h10;
  localparam logic [7:0] REG_UPDATES = 8'h14;
  localparam logic [7:0] REG_REJECTS = 8'h18;

  // Control register field positions
  localparam int unsigned CTRL_ENABLE_BIT = 0;
  localparam int unsigned CTRL_LAND_BIT   = 1;
  localparam int unsigned CTRL_ZONE_BIT   = 2;
  localparam int unsigned CTRL_QUAL_BIT   = 3;

  // Timing register field positions (start of each field after sync)
  localparam int unsigned TIMING_LAND_LSB   = 0;
  localparam int unsigned TIMING_GROOVE_LSB = 16;
  localparam int unsigned TIMING_FIELD_W    = 12;

  // Reset values
  localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
  localparam logic [31:0] THRESH_RESET = 32'h0000_0000;
  localparam logic [31:0] TIMING_RESET = 32'h0050_0010;

  // AXI4-Lite responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // One side's four wobble-mark samples
  typedef struct packed {
    logic [7:0] spaceRef;
    logic [7:0] firstMark;
    logic [7:0] secondMark;
    logic [7:0] markRef;
  } mark_set_t;

  typedef enum logic [1:0] {
    SUB_SPACE,
    SUB_FIRST,
    SUB_SECOND,
    SUB_MARKREF
  } sub_field_t;

endpackage : wobble_mark_pkg

/* design/wobble_mark_track_offset.sv */
// Wobble-mark tracking offset correction with AXI4-Lite registers
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the register addresses.
module wobble_mark_track_offset
  import wobble_mark_pkg::*;
#(
  parameter int unsigned SAMPLE_W = 8
)(
  input  wire logic                mclk,
  input  wire logic                reset,
  // Read channel side
  input  wire logic                headerSyncPattern,
  input  wire logic                bitStrobe,
  input  wire logic [SAMPLE_W-1:0] readLevel,
  // Tracking servo side
  output logic signed [SAMPLE_W:0] trackOffsetValue,
  output logic                     offsetStrobe,
  output logic                     offsetValid,
  // AXI4-Lite slave
  input  wire logic [7:0]          s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [7:0]          s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready
);

  localparam logic [11:0] FIELD_LEN  = 12'(FIELD_LEN_T);
  localparam logic [11:0] SAMPLE_POS = 12'(SAMPLE_POS_T);
  localparam logic [11:0] HDR_END    = 12'(HEADER_LIMIT_T);

  logic [31:0]                ctrl_ff;
  logic [31:0]                thresh_ff;
  logic [31:0]                timing_ff;
  logic [31:0]                updates_ff;
  logic [31:0]                rejects_ff;
  logic [11:0]                tCount_ff;
  logic                       inHeader_ff;
  mark_set_t                  land_ff;
  mark_set_t                  groove_ff;
  logic [7:0]                 taken_ff;
  logic                       compute_ff;
  logic                       lastReject_ff;
  logic signed [SAMPLE_W:0]   offset_ff;
  logic                       strobe_ff;
  logic                       valid_ff;
  logic                       awready_ff;
  logic                       wready_ff;
  logic                       bvalid_ff;
  logic [1:0]                 bresp_ff;
  logic                       arready_ff;
  logic                       rvalid_ff;
  logic [31:0]                rdata_ff;
  logic [1:0]                 rresp_ff;

  logic                       enable;
  logic                       followLand;
  logic                       nearZone;
  logic                       qualEnable;
  logic [11:0]                landStart;
  logic [11:0]                grooveStart;
  logic [11:0]                landRel;
  logic [11:0]                grooveRel;
  logic                       landHit;
  logic                       grooveHit;
  sub_field_t                 landSub;
  sub_field_t                 grooveSub;
  mark_set_t                  usedSet;
  logic                       pairForward;
  logic signed [SAMPLE_W:0]   nxt_offset;
  logic [SAMPLE_W:0]          refSpan;
  logic                       qualOk;
  logic                       accept;
  logic                       wrTake;
  logic                       rdTake;

  assign enable      = ctrl_ff[CTRL_ENABLE_BIT];
  assign followLand  = ctrl_ff[CTRL_LAND_BIT];
  assign nearZone    = ctrl_ff[CTRL_ZONE_BIT];
  assign qualEnable  = ctrl_ff[CTRL_QUAL_BIT];
  assign landStart   = timing_ff[TIMING_LAND_LSB +: TIMING_FIELD_W];
  assign grooveStart = timing_ff[TIMING_GROOVE_LSB +: TIMING_FIELD_W];

  // Bit-period count from header sync
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      tCount_ff   <= 12'h000;
      inHeader_ff <= 1'b0;
    end
    else if (headerSyncPattern && enable)
    begin
      tCount_ff   <= 12'h000;
      inHeader_ff <= 1'b1;
    end
    else if (inHeader_ff && bitStrobe)
    begin
      tCount_ff <= tCount_ff + 12'h001;
      if (tCount_ff == HDR_END || compute_ff)
        inHeader_ff <= 1'b0;
    end
    else if (compute_ff)
      inHeader_ff <= 1'b0;
  end

  // Mid sub-field sample points inside each 64T field
  always_comb
  begin
    landRel   = tCount_ff - landStart;
    grooveRel = tCount_ff - grooveStart;
    landHit   = inHeader_ff && bitStrobe && (tCount_ff >= landStart) &&
                (landRel < FIELD_LEN) && (landRel[3:0] == SAMPLE_POS[3:0]);
    grooveHit = inHeader_ff && bitStrobe && (tCount_ff >= grooveStart) &&
                (grooveRel < FIELD_LEN) &&
                (grooveRel[3:0] == SAMPLE_POS[3:0]);
    landSub   = sub_field_t'(landRel[5:4]);
    grooveSub = sub_field_t'(grooveRel[5:4]);
  end

  // Sample capture, four per side
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      land_ff   <= '0;
      groove_ff <= '0;
      taken_ff  <= 8'h00;
    end
    else if (headerSyncPattern && enable)
      taken_ff <= 8'h00;
    else
    begin
      if (landHit)
      begin
        case (landSub)
          SUB_SPACE:   land_ff.spaceRef   <= readLevel;
          SUB_FIRST:   land_ff.firstMark  <= readLevel;
          SUB_SECOND:  land_ff.secondMark <= readLevel;
          SUB_MARKREF: land_ff.markRef    <= readLevel;
          default:     land_ff.markRef    <= readLevel;
        endcase
        taken_ff[{1'b0, landRel[5:4]}] <= 1'b1;
      end
      if (grooveHit)
      begin
        case (grooveSub)
          SUB_SPACE:   groove_ff.spaceRef   <= readLevel;
          SUB_FIRST:   groove_ff.firstMark  <= readLevel;
          SUB_SECOND:  groove_ff.secondMark <= readLevel;
          SUB_MARKREF: groove_ff.markRef    <= readLevel;
          default:     groove_ff.markRef    <= readLevel;
        endcase
        taken_ff[{1'b1, grooveRel[5:4]}] <= 1'b1;
      end
    end
  end

  // Fires once when all eight samples of this header are in
  always_ff @(posedge mclk)
  begin
    if (reset)
      compute_ff <= 1'b0;
    else
      compute_ff <= inHeader_ff && (taken_ff == 8'hff) && !compute_ff;
  end

  // Offset arithmetic and qualification of the side in use
  always_comb
  begin
    if (followLand)
    begin
      usedSet     = groove_ff;
      pairForward = land_ff.firstMark < land_ff.secondMark;
    end
    else
    begin
      usedSet     = land_ff;
      pairForward = groove_ff.firstMark > groove_ff.secondMark;
    end
    // Mark level below space level; equal marks give zero
    if (pairForward)
      nxt_offset = $signed({1'b0, usedSet.firstMark}) -
                   $signed({1'b0, usedSet.secondMark});
    else
      nxt_offset = $signed({1'b0, usedSet.secondMark}) -
                   $signed({1'b0, usedSet.firstMark});
    refSpan = {1'b0, usedSet.spaceRef} - {1'b0, usedSet.markRef};
    qualOk  = (usedSet.spaceRef > usedSet.markRef) &&
              (usedSet.spaceRef > usedSet.firstMark) &&
              (usedSet.firstMark > usedSet.markRef) &&
              (usedSet.spaceRef > usedSet.secondMark) &&
              (usedSet.secondMark > usedSet.markRef) &&
              (refSpan > thresh_ff[SAMPLE_W:0]);
    accept  = !nearZone && (!qualEnable || qualOk);
  end

  // Servo-facing offset, held when rejected
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      offset_ff     <= '0;
      strobe_ff     <= 1'b0;
      valid_ff      <= 1'b0;
      lastReject_ff <= 1'b0;
    end
    else
    begin
      strobe_ff <= compute_ff;
      if (compute_ff)
      begin
        valid_ff      <= accept;
        lastReject_ff <= !accept;
        if (accept)
          offset_ff <= nxt_offset;
      end
    end
  end

  // Update and reject counters
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      updates_ff <= 32'h0000_0000;
      rejects_ff <= 32'h0000_0000;
    end
    else if (compute_ff)
    begin
      if (accept)
        updates_ff <= updates_ff + 32'h0000_0001;
      else
        rejects_ff <= rejects_ff + 32'h0000_0001;
    end
  end

  // AXI4-Lite write: address and data taken together
  assign wrTake = s_axi_awvalid && s_axi_wvalid && !awready_ff &&
                  !bvalid_ff;

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= RESP_OKAY;
    end
    else
    begin
      awready_ff <= wrTake;
      wready_ff  <= wrTake;
      if (wrTake)
      begin
        bvalid_ff <= 1'b1;
        if (s_axi_awaddr == REG_CTRL || s_axi_awaddr == REG_THRESH ||
            s_axi_awaddr == REG_TIMING)
          bresp_ff <= RESP_OKAY;
        else
          bresp_ff <= RESP_SLVERR;
      end
      else if (bvalid_ff && s_axi_bready)
        bvalid_ff <= 1'b0;
    end
  end

  // Writable registers with byte strobes
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      ctrl_ff   <= CTRL_RESET;
      thresh_ff <= THRESH_RESET;
      timing_ff <= TIMING_RESET;
    end
    else if (wrTake)
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (s_axi_wstrb[i])
        begin
          if (s_axi_awaddr == REG_CTRL)
            ctrl_ff[i*8 +: 8] <= s_axi_wdata[i*8 +: 8];
          else if (s_axi_awaddr == REG_THRESH)
            thresh_ff[i*8 +: 8] <= s_axi_wdata[i*8 +: 8];
          else if (s_axi_awaddr == REG_TIMING)
            timing_ff[i*8 +: 8] <= s_axi_wdata[i*8 +: 8];
        end
      end
    end
  end

  // AXI4-Lite read
  assign rdTake = s_axi_arvalid && !arready_ff && !rvalid_ff;

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h0000_0000;
      rresp_ff   <= RESP_OKAY;
    end
    else
    begin
      arready_ff <= rdTake;
      if (rdTake)
      begin
        rvalid_ff <= 1'b1;
        rresp_ff  <= RESP_OKAY;
        if (s_axi_araddr == REG_CTRL)
          rdata_ff <= {28'h0000000, ctrl_ff[3:0]};
        else if (s_axi_araddr == REG_THRESH)
          rdata_ff <= thresh_ff;
        else if (s_axi_araddr == REG_TIMING)
          rdata_ff <= timing_ff;
        else if (s_axi_araddr == REG_STATUS)
          rdata_ff <= {22'h000000, taken_ff, lastReject_ff, valid_ff};
        else if (s_axi_araddr == REG_OFFSET)
          rdata_ff <= 32'(offset_ff);
        else if (s_axi_araddr == REG_UPDATES)
          rdata_ff <= updates_ff;
        else if (s_axi_araddr == REG_REJECTS)
          rdata_ff <= rejects_ff;
        else
        begin
          rdata_ff <= 32'h0000_0000;
          rresp_ff <= RESP_SLVERR;
        end
      end
      else if (rvalid_ff && s_axi_rready)
        rvalid_ff <= 1'b0;
    end
  end

  assign trackOffsetValue = offset_ff;
  assign offsetStrobe     = strobe_ff;
  assign offsetValid      = valid_ff;
  assign s_axi_awready    = awready_ff;
  assign s_axi_wready     = wready_ff;
  assign s_axi_bvalid     = bvalid_ff;
  assign s_axi_bresp      = bresp_ff;
  assign s_axi_arready    = arready_ff;
  assign s_axi_rvalid     = rvalid_ff;
  assign s_axi_rdata      = rdata_ff;
  assign s_axi_rresp      = rresp_ff;

endmodule : wobble_mark_track_offset

/* testbench/wobble_mark_asserts.sv */
// Checker for offset outputs and register bus handshakes
module wobble_mark_asserts
  import wobble_mark_pkg::*;
#(
  parameter int unsigned SAMPLE_W = 8
)(
  input wire logic                     mclk,
  input wire logic                     reset,
  input wire logic signed [SAMPLE_W:0] trackOffsetValue,
  input wire logic                     offsetStrobe,
  input wire logic                     offsetValid,
  input wire logic                     s_axi_awvalid,
  input wire logic                     s_axi_awready,
  input wire logic                     s_axi_wvalid,
  input wire logic                     s_axi_wready,
  input wire logic                     s_axi_bvalid,
  input wire logic                     s_axi_bready,
  input wire logic                     s_axi_arvalid,
  input wire logic                     s_axi_arready,
  input wire logic [31:0]              s_axi_rdata,
  input wire logic                     s_axi_rvalid,
  input wire logic                     s_axi_rready
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);
  sequence wrTake;
    s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
  endsequence
  sequence wrAnswer;
    s_axi_awready && s_axi_wready && s_axi_bvalid;
  endsequence
  strobe_pulse_a: assert property (offsetStrobe |=> !offsetStrobe)
    else $error("offset strobe longer than one cycle");
  offset_hold_a: assert property (!offsetStrobe |->
    $stable(trackOffsetValue))
    else $error("offset changed without strobe");
  valid_hold_a: assert property (!offsetStrobe |-> $stable(offsetValid))
    else $error("valid changed without strobe");
  reject_keep_a: assert property (offsetStrobe && !offsetValid |->
    $stable(trackOffsetValue))
    else $error("rejected update changed offset");
  write_answer_a: assert property (wrTake |=> wrAnswer)
    else $error("write not answered next cycle");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  read_answer_a: assert property (s_axi_arvalid && !s_axi_arready &&
    !s_axi_rvalid |=> s_axi_arready && s_axi_rvalid)
    else $error("read not answered next cycle");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
endmodule : wobble_mark_asserts

bind wobble_mark_track_offset wobble_mark_asserts #(.SAMPLE_W(SAMPLE_W))
  chk (.*);

/* testbench/read_channel_model.sv */
// Read channel model: header sync, bit strobes and sampled levels
module read_channel_model
  import wobble_mark_pkg::*;
(
  input  wire logic       mclk,
  output logic            headerSyncPattern,
  output logic            bitStrobe,
  output logic [7:0]      readLevel
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    headerSyncPattern = 1'b0;
    bitStrobe = 1'b0;
    readLevel = 8'h00;
  end
  // Level over bit n; land from 16, groove from 80; sub-field edges garbled
  function automatic logic [7:0] level(mark_set_t l, mark_set_t g, int n);
    mark_set_t s;
    s = (n < 80) ? l : g;
    if (n < 16 || n > 143 || (n - 16) % 16 < 4 || (n - 16) % 16 > 12)
      return n[7:0] ^ 8'ha5;
    return s[31 - 8 * (((n - 16) % 64) / 16) -: 8];
  endfunction : level
  task automatic header(mark_set_t l, mark_set_t g, int gap);
    @(posedge mclk);
    headerSyncPattern <= 1'b1;
    @(posedge mclk);
    headerSyncPattern <= 1'b0;
    for (int n = 0; n < 150; n++)
    begin
      readLevel <= level(l, g, n);
      bitStrobe <= 1'b1;
      @(posedge mclk);
      if (gap > 0)
      begin
        bitStrobe <= 1'b0;
        readLevel <= ~level(l, g, n);
        repeat (gap) @(posedge mclk);
      end
    end
    bitStrobe <= 1'b0;
  endtask : header
endmodule : read_channel_model

/* testbench/test_wobble_mark_track_offset.sv */
// Self-checking bench for the wobble-mark track offset block
module test_wobble_mark_track_offset
  import wobble_mark_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic              mclk = 1'b0;
  logic              reset = 1'b1;
  logic              headerSyncPattern;
  logic              bitStrobe;
  logic [7:0]        readLevel;
  logic signed [8:0] trackOffsetValue;
  logic              offsetStrobe;
  logic              offsetValid;
  logic [7:0]        s_axi_awaddr = 8'h00;
  logic [7:0]        s_axi_araddr = 8'h00;
  logic [31:0]       s_axi_wdata = 32'h0;
  logic [31:0]       s_axi_rdata;
  logic [3:0]        s_axi_wstrb = 4'hf;
  logic [1:0]        s_axi_bresp;
  logic [1:0]        s_axi_rresp;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [31:0]       lastOff = 32'h0;
  int                failures = 0;
  int                n_checks = 0;
  int                nStrobe = 0;

  wobble_mark_track_offset dut (.*);
  read_channel_model chan (.*);

  always #10 mclk = ~mclk;
  always @(posedge mclk)
    if (offsetStrobe === 1'b1)
      nStrobe <= nStrobe + 1;

  task automatic final_report;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : final_report
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  function automatic logic hs(int w);
    case (w)
      0: return s_axi_awready;
      1: return s_axi_bvalid;
      2: return s_axi_arready;
      default: return s_axi_rvalid;
    endcase
  endfunction : hs
  task automatic wait_hi(int w);
    int i;
    for (i = 0; i < 50 && hs(w) !== 1'b1; i++)
      @(posedge mclk);
    if (i == 50)
    begin
      failures++;
      $display("[ERR] handshake %0d expected 1 seen %b", w, hs(w));
      final_report();
    end
  endtask : wait_hi
  task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] er);
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    wait_hi(0);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    s_axi_bready <= 1'b1;
    @(posedge mclk);
    wait_hi(1);
    check("bresp", er, s_axi_bresp);
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rc(string n, logic [7:0] a, logic [31:0] ed, logic [1:0] er);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    wait_hi(2);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    @(posedge mclk);
    wait_hi(3);
    check(n, ed, s_axi_rdata);
    check("rresp", er, s_axi_rresp);
    s_axi_rready <= 1'b0;
  endtask : rc
  function automatic logic [31:0] eoff(logic land, mark_set_t l, mark_set_t g);
    mark_set_t u;
    logic      swap;
    u = land ? g : l;
    swap = land ? (l.firstMark >= l.secondMark)
                : (g.firstMark <= g.secondMark);
    if (swap)
      return 32'($signed(9'(u.secondMark) - 9'(u.firstMark)));
    return 32'($signed(9'(u.firstMark) - 9'(u.secondMark)));
  endfunction : eoff
  task automatic hdr(logic land, mark_set_t l, mark_set_t g, int gap,
                     logic ev, int en);
    int n0;
    n0 = nStrobe;
    if (ev)
      lastOff = eoff(land, l, g);
    chan.header(l, g, gap);
    repeat (4) @(posedge mclk);
    check("strobe count", en, nStrobe - n0);
    check("offset", lastOff, trackOffsetValue);
    if (en)
      check("valid", ev, offsetValid);
  endtask : hdr

  task automatic t_regs;
    rc("ctrl", REG_CTRL, CTRL_RESET, RESP_OKAY);
    rc("thresh", REG_THRESH, THRESH_RESET, RESP_OKAY);
    rc("timing", REG_TIMING, TIMING_RESET, RESP_OKAY);
    wr(REG_THRESH, 32'h1ff, RESP_OKAY);
    rc("thresh wr", REG_THRESH, 32'h1ff, RESP_OKAY);
    rc("unmapped", 8'h1c, 32'h0, RESP_SLVERR);
    wr(REG_OFFSET, 32'h5, RESP_SLVERR);
    rc("offset ro", REG_OFFSET, 32'h0, RESP_OKAY);
  endtask : t_regs
  task automatic t_track;
    mark_set_t t[4] = '{32'hc0907020, 32'hc0709020, 32'hc0808020,
                        32'hc0a06020};
    for (int s = 0; s < 2; s++)
    begin
      wr(REG_CTRL, {30'h0, s[0], 1'b1}, RESP_OKAY);
      for (int i = 0; i < 4; i++)
        hdr(s[0], t[s?3-i:i], t[s?i:3-i], i%2, 1'b1, 1);
    end
    rc("offset reg", REG_OFFSET, lastOff, RESP_OKAY);
  endtask : t_track
  task automatic t_qual;
    mark_set_t q[6] = '{32'hc0907020, 32'hc0d07020, 32'h20907060,
                        32'h60504020, 32'hc0902020, 32'h61504020};
    logic ok[6] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
    wr(REG_THRESH, 32'h40, RESP_OKAY);
    wr(REG_CTRL, 32'h9, RESP_OKAY);
    rc("ctrl wr", REG_CTRL, 32'h9, RESP_OKAY);
    for (int i = 0; i < 6; i++)
      hdr(1'b0, q[i], 32'hc0a06020, 0, ok[i], 1);
    wr(REG_CTRL, 32'hb, RESP_OKAY);
    hdr(1'b1, 32'hc0907020, 32'h20907060, 0, 1'b0, 1);
  endtask : t_qual
  task automatic t_zone;
    wr(REG_CTRL, 32'h5, RESP_OKAY);
    hdr(1'b0, 32'hc0709020, 32'hc0a06020, 1, 1'b0, 1);
    wr(REG_CTRL, 32'h0, RESP_OKAY);
    hdr(1'b0, 32'hc0907020, 32'hc0a06020, 0, 1'b0, 0);
    rc("updates", REG_UPDATES, 32'ha, RESP_OKAY);
    rc("rejects", REG_REJECTS, 32'h6, RESP_OKAY);
    rc("status", REG_STATUS, 32'h3fe, RESP_OKAY);
  endtask : t_zone

  initial
  begin
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    t_regs();
    t_track();
    t_qual();
    t_zone();
    final_report();
  end
endmodule : test_wobble_mark_track_offset
